/* hw/cos_pkg.sv */
package cos_pkg;

	// register map
	localparam logic [3:0] CTRL_OFFSET = 4'h0;
	localparam logic [7:0] CTRL_RESET  = 8'h00;

	// field positions of comparator_output_control
	localparam int MIRROR_A_BIT  = 7;
	localparam int MIRROR_B_BIT  = 6;
	localparam int REF_SEL_A_BIT = 5;
	localparam int REF_SEL_B_BIT = 4;
	localparam int HYS_A_BIT     = 3;
	localparam int HYS_B_BIT     = 2;
	localparam int SYNC_A_BIT    = 1;
	localparam int SYNC_B_BIT    = 0;

	// writable field mask (mirrors are read-only)
	localparam logic [7:0] CTRL_WR_MASK = 8'h3f;

	// prescaler default ratio log2 (1:1)
	localparam int PRESCALE_LOG2_RESET = 0;

	// per-comparator configuration
	typedef struct packed {
		logic ref_select;
		logic hysteresis_enable;
		logic timer_sync_enable;
	} cos_cmp_cfg_t;

	// register bus request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} cos_bus_req_t;

endpackage : cos_pkg

/* hw/cos_sync_latch.sv */
`timescale 1ns/1ps
module cos_sync_latch
	import cos_pkg::*;
(
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_reset,
	// control
	input  wire logic i_timer_edge,
	input  wire logic i_sync_enable,
	// comparator
	input  wire logic i_cmp_raw,
	output logic      o_cmp_out
);

	logic latched;

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			latched <= 1'b0;
		end else if (i_timer_edge) begin
			latched <= i_cmp_raw;
		end
	end

	assign o_cmp_out = i_sync_enable ? latched : i_cmp_raw;

endmodule : cos_sync_latch

/* hw/cos_comparator_output_sync.sv */
`timescale 1ns/1ps
module cos_comparator_output_sync
	import cos_pkg::*;
#(
	parameter int PRESCALE_LOG2_MAX = 3,
	parameter int TIMER_WIDTH       = 16
) (
	// clock and reset
	input  wire logic                   i_clk,
	input  wire logic                   i_reset,
	// register port
	input  wire logic [3:0]             i_addr,
	input  wire logic [7:0]             i_wdata,
	input  wire logic                   i_wr,
	input  wire logic                   i_rd,
	output logic      [7:0]             o_rdata,
	// timer source and prescaler
	input  wire logic                   i_timer_src_clk,
	input  wire logic [1:0]             i_prescale_log2,
	output logic      [TIMER_WIDTH-1:0] o_timer_count,
	// comparator cores
	input  wire logic                   i_cmp_a_raw,
	input  wire logic                   i_cmp_b_raw,
	output logic                        o_cmp_a_output,
	output logic                        o_cmp_b_output,
	// analog configuration
	output logic                        o_cmp_a_ref_select,
	output logic                        o_cmp_b_ref_select,
	output logic                        o_cmp_a_hysteresis_enable,
	output logic                        o_cmp_b_hysteresis_enable
);

	// decode
	cos_bus_req_t bus;
	logic         hit;
	logic         wr_hit;
	logic         rd_hit;

	// configuration
	cos_cmp_cfg_t cfg_a;
	cos_cmp_cfg_t cfg_b;
	logic [5:0]   ctrl;

	// timer path
	logic         src_prev;
	logic         src_rise;
	logic [1:0]   prescale_sel;
	logic [7:0]   prescale_cnt;
	logic [7:0]   prescale_top;
	logic         prescale_wrap;
	logic         timer_edge;

	// readback
	logic [7:0]   read_word;

	// port flattened into one carrier so decode sees one word
	assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

	// only one register is mapped; other offsets are ignored
	always_comb begin
		unique case (bus.addr)
			CTRL_OFFSET: begin
				hit = 1'b1;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
	end

	// strobes qualified once so every consumer agrees on a hit
	assign wr_hit = bus.wr && hit;
	assign rd_hit = bus.rd && hit;

	// writable control bits; mirrors never stored here
	// bits 7 and 6 of a write have no flop and are dropped
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			ctrl <= CTRL_RESET[5:0];
		end else if (wr_hit) begin
			ctrl[REF_SEL_A_BIT] <= bus.wdata[REF_SEL_A_BIT];
			ctrl[REF_SEL_B_BIT] <= bus.wdata[REF_SEL_B_BIT];
			ctrl[HYS_A_BIT]     <= bus.wdata[HYS_A_BIT];
			ctrl[HYS_B_BIT]     <= bus.wdata[HYS_B_BIT];
			ctrl[SYNC_A_BIT]    <= bus.wdata[SYNC_A_BIT];
			ctrl[SYNC_B_BIT]    <= bus.wdata[SYNC_B_BIT];
		end
	end

	// per-comparator view of the control bits
	always_comb begin
		cfg_a.ref_select        = ctrl[REF_SEL_A_BIT];
		cfg_a.hysteresis_enable = ctrl[HYS_A_BIT];
		cfg_a.timer_sync_enable = ctrl[SYNC_A_BIT];
	end

	always_comb begin
		cfg_b.ref_select        = ctrl[REF_SEL_B_BIT];
		cfg_b.hysteresis_enable = ctrl[HYS_B_BIT];
		cfg_b.timer_sync_enable = ctrl[SYNC_B_BIT];
	end

	assign o_cmp_a_ref_select        = cfg_a.ref_select;
	assign o_cmp_b_ref_select        = cfg_b.ref_select;

	assign o_cmp_a_hysteresis_enable = cfg_a.hysteresis_enable;
	assign o_cmp_b_hysteresis_enable = cfg_b.hysteresis_enable;

	// timer source is sampled; rising edge becomes one-cycle enable
	// limitation: source must stay high and low a clock each
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			// tracks the pin in reset, so no false edge follows
			src_prev <= i_timer_src_clk;
		end else begin
			src_prev <= i_timer_src_clk;
		end
	end
	// one-cycle pulse per source rise
	assign src_rise = i_timer_src_clk & ~src_prev;

	// ratio above the supported maximum is held at the maximum
	// only reachable when the maximum is set below three
	always_comb begin
		if (int'(i_prescale_log2) > PRESCALE_LOG2_MAX) begin
			prescale_sel = 2'(PRESCALE_LOG2_MAX);
		end else begin
			prescale_sel = i_prescale_log2;
		end
	end

	assign prescale_top  = 8'((9'h001 << prescale_sel) - 9'h001);
	// compare is >= so a ratio lowered mid-count wraps at once
	assign prescale_wrap = (prescale_cnt >= prescale_top);

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			prescale_cnt <= 8'h00;
		end else if (src_rise) begin
			if (prescale_wrap) begin
				prescale_cnt <= 8'h00;
			end else begin
				prescale_cnt <= prescale_cnt + 8'h01;
			end
		end
	end

	// same pulse feeds counter and latches, so no race
	assign timer_edge = src_rise && prescale_wrap;

	// counter steps on the same edge
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_timer_count <= '0;
		end else if (timer_edge) begin
			// wraps silently; no overflow flag is kept
			o_timer_count <= o_timer_count + TIMER_WIDTH'(1);
		end
	end

	// sync enables select latched or raw
	cos_sync_latch u_latch_a (
		.i_clk         (i_clk),
		.i_reset       (i_reset),
		.i_timer_edge  (timer_edge),
		.i_sync_enable (cfg_a.timer_sync_enable),
		.i_cmp_raw     (i_cmp_a_raw),
		.o_cmp_out     (o_cmp_a_output)
	);

	// b shares the edge, so both mirrors stay aligned
	cos_sync_latch u_latch_b (
		.i_clk         (i_clk),
		.i_reset       (i_reset),
		.i_timer_edge  (timer_edge),
		.i_sync_enable (cfg_b.timer_sync_enable),
		.i_cmp_raw     (i_cmp_b_raw),
		.o_cmp_out     (o_cmp_b_output)
	);

	// both taken in one cycle, so no skew between them
	always_comb begin
		read_word                = 8'h00;
		// status
		read_word[MIRROR_A_BIT]  = o_cmp_a_output;
		read_word[MIRROR_B_BIT]  = o_cmp_b_output;
		// configuration
		read_word[REF_SEL_A_BIT] = cfg_a.ref_select;
		read_word[REF_SEL_B_BIT] = cfg_b.ref_select;
		read_word[HYS_A_BIT]     = cfg_a.hysteresis_enable;
		read_word[HYS_B_BIT]     = cfg_b.hysteresis_enable;
		read_word[SYNC_A_BIT]    = cfg_a.timer_sync_enable;
		read_word[SYNC_B_BIT]    = cfg_b.timer_sync_enable;
	end

	// read data one cycle after strobe; zero otherwise
	// zero between reads keeps a stale value off a shared bus
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_rdata <= 8'h00;
		end else if (rd_hit) begin
			o_rdata <= read_word;
		end else begin
			o_rdata <= 8'h00;
		end
	end

endmodule : cos_comparator_output_sync

/* verif/cos_chk_assertions.sv */
`timescale 1ns/1ps
module cos_chk
	import cos_pkg::*;
#(parameter int TIMER_WIDTH = 16) (
	input wire logic i_clk, i_reset, i_wr, i_rd, i_timer_src_clk,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata, o_rdata,
	input wire logic [1:0] i_prescale_log2,
	input wire logic [TIMER_WIDTH-1:0] o_timer_count,
	input wire logic i_cmp_a_raw, o_cmp_a_output, o_cmp_a_ref_select,
	input wire logic o_cmp_b_ref_select, o_cmp_a_hysteresis_enable,
	input wire logic o_cmp_b_hysteresis_enable
);
	logic sync_a;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	// shadow of the sync bit, not visible at the ports
	always_ff @(posedge i_clk) begin
		if (i_reset) sync_a <= 1'b0;
		else if (i_wr && i_addr == CTRL_OFFSET) sync_a <= i_wdata[SYNC_A_BIT];
	end
	sequence wr0; i_wr && i_addr == CTRL_OFFSET; endsequence
	sequence rise0; $rose(i_timer_src_clk) && i_prescale_log2 == 2'h0;
	endsequence
	cfg_write_a: assert property (wr0 |=>
		{o_cmp_a_ref_select, o_cmp_b_ref_select, o_cmp_a_hysteresis_enable,
		o_cmp_b_hysteresis_enable} == $past(i_wdata[5:2])) else $error("cfg");
	rd_idle_a: assert property (!(i_rd && i_addr == CTRL_OFFSET) |=>
		o_rdata == 8'h00) else $error("idle read");
	rd_mirror_a: assert property (i_rd && i_addr == CTRL_OFFSET |=>
		o_rdata[7] == $past(o_cmp_a_output)) else $error("mirror");
	async_pass_a: assert property (!sync_a |->
		o_cmp_a_output == i_cmp_a_raw) else $error("bypass");
	sync_latch_a: assert property ((sync_a && !i_wr) ##0 rise0
		|=> o_cmp_a_output == $past(i_cmp_a_raw)) else $error("latch");
	count_step_a: assert property (rise0 |=>
		o_timer_count == $past(o_timer_count) + 1'b1) else $error("count");
	count_hold_a: assert property (!$rose(i_timer_src_clk) |=>
		$stable(o_timer_count)) else $error("count moved");
	latch_hold_a: assert property ((sync_a && !i_wr) ##1
		$stable(o_timer_count) |-> $stable(o_cmp_a_output))
		else $error("latch moved");
endmodule : cos_chk
bind cos_comparator_output_sync cos_chk #(.TIMER_WIDTH(TIMER_WIDTH))
	u_chk (.*);

/* verif/cos_comparator_output_sync_bench.sv */
`timescale 1ns/1ps
module cos_comparator_output_sync_bench;
	import cos_pkg::*;
	logic i_clk = '0, i_reset = '1, i_wr = '0, i_rd = '0, src = '0;
	logic ra = '0, rb = '0, oa, ob;
	logic [1:0] psc = '0;
	logic [3:0] i_addr = '0;
	logic [7:0] i_wdata = '0, rdata;
	logic [15:0] cnt, exp = '0;
	logic [3:0] cfg_out;
	int bad_count = 0, check_count = 0, cyc = 0;
	cos_comparator_output_sync uut (.i_clk, .i_reset, .i_addr, .i_wdata,
		.i_wr, .i_rd, .o_rdata(rdata), .i_timer_src_clk(src),
		.i_prescale_log2(psc), .o_timer_count(cnt), .i_cmp_a_raw(ra),
		.i_cmp_b_raw(rb), .o_cmp_a_output(oa), .o_cmp_b_output(ob),
		.o_cmp_a_ref_select(cfg_out[3]), .o_cmp_b_ref_select(cfg_out[2]),
		.o_cmp_a_hysteresis_enable(cfg_out[1]),
		.o_cmp_b_hysteresis_enable(cfg_out[0]));
	initial forever #10 i_clk = ~i_clk;
	task automatic summarize();
		if (bad_count == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : summarize
	task automatic chk(input logic [15:0] got, want);
		check_count++;
		if (got !== want) begin
			bad_count++;
			$display("wrong value at %0t: %h, expected %h", $time, got, want);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1'h1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'h0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge i_clk);
		i_rd <= 1'h1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'h0;
		#1 chk(rdata, e);
	endtask : rd
	// slow source edges so the rise detector sees every one
	task automatic tick();
		@(posedge i_clk) src <= 1'h1;
		repeat (2) @(posedge i_clk);
		src <= 1'h0;
		repeat (2) @(posedge i_clk);
	endtask : tick
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			summarize();
		end
	end
	initial begin
		repeat (10) @(posedge i_clk);
		i_reset <= 1'h0;
		rd(4'h0, CTRL_RESET);
		wr(4'h0, 8'hff);
		#1 chk(16'(cfg_out), 16'hf);
		rd(4'h0, CTRL_WR_MASK);
		wr(4'h0, 8'h28);
		#1 chk(16'(cfg_out), 16'ha);
		wr(4'h5, 8'hff);
		#1 chk(16'(cfg_out), 16'ha);
		rd(4'h5, 8'h00);
		wr(4'h0, 8'h00);
		ra <= 1'h1;
		#1 chk(16'(cfg_out), 16'h0);
		rd(4'h0, 8'h80);
		wr(4'h0, 8'h03);
		tick();
		@(posedge i_clk) ra <= 1'h0;
		rb <= 1'h1;
		#1 chk({ob, oa}, 2'h1);
		rd(4'h0, 8'h83);
		tick();
		#1 chk({ob, oa}, 2'h2);
		exp = 16'h2;
		chk(cnt, exp);
		for (int n = 0; n < 4; n++) begin
			@(posedge i_clk) psc <= 2'(n);
			repeat (8) tick();
			exp += 16'(8 >> n);
			#1 chk(cnt, exp);
		end
		summarize();
	end
endmodule : cos_comparator_output_sync_bench
